// >>> rtl/memory_reference_steering.sv
// Steering of CPU references through receivers, routers and bank controllers
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "steer_defines.svh"
module memory_reference_steering (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CPU access paths, lower and upper halves
	input wire steer_pkg::half_in_type [`NPORT-1:0] lo_in,
	input wire steer_pkg::half_in_type [`NPORT-1:0] hi_in,
	output logic [`NPORT-1:0] lo_resume,
	output logic [`NPORT-1:0] hi_resume,
	output steer_pkg::half_out_type [`NPORT-1:0] lo_out,
	output steer_pkg::half_out_type [`NPORT-1:0] hi_out,
	// Memory stack, one per section
	output steer_pkg::mem_out_type [`NSECT-1:0] mem_out,
	input wire logic [`NSECT-1:0][`STACK_W-1:0] mem_rdata
);

	steer_pkg::state_type st_r;
	steer_pkg::state_type st_nxt;
	logic [`NSECT-1:0][`WORD_W-1:0] word_in;
	logic [`NSECT-1:0][`STACK_W-1:0] word_out;
	logic [`NSECT-1:0][`WORD_W-1:0] unshift;

	// Spare bit shifting, one slice per bit
	genvar s;
	genvar i;
	generate
		for (s = 0; s < `NSECT; s++) begin : g_sect
			for (i = 0; i < `STACK_W; i++) begin : g_bit
				if (i == 0) begin : g_first
					assign word_out[s][i] = word_in[s][i];
				end else if (i == `STACK_W - 1) begin : g_top
					assign word_out[s][i] = st_r.spare_en ? word_in[s][i-1] : 1'b0; // RULE_16
				end else begin : g_mid
					assign word_out[s][i] = (st_r.spare_en && i > st_r.spare_pos) ?
						word_in[s][i-1] : word_in[s][i]; // RULE_16
				end
				if (i < `WORD_W) begin : g_rd
					assign unshift[s][i] = (st_r.spare_en && i >= st_r.spare_pos) ?
						mem_rdata[s][i+1] : mem_rdata[s][i]; // RULE_16
				end
			end
		end
	endgenerate

	// Grant, data and completion scratch
	logic [`NSECT-1:0] grant_any;
	logic [`NSECT-1:0][1:0] grant_idx;
	logic [`NSECT-1:0] resp_v;

	always_comb begin
		int p;
		int q;
		logic [3:0] rt;
		logic [`WORD_W-1:0] rd;
		logic [`DEST_W-1:0] dst;
		logic [3:0] rbank;
		st_nxt = st_r;
		word_in = '0;
		grant_any = '0;
		grant_idx = '0;
		resp_v = '0;
		p = 0;
		q = 0;
		rt = '0;
		rd = '0;
		dst = '0;
		rbank = '0;

		// Port receivers, halves qualified on their own
		for (p = 0; p < `NPORT; p++) begin
			if (!st_r.port[p].pend) begin
				if (lo_in[p].valid && !st_r.port[p].lo_got) begin // RULE_18
					st_nxt.port[p].lo_got = 1'b1;
					st_nxt.port[p].wr = lo_in[p].write_ref;
					if (!st_r.port[p].phase) begin // RULE_17
						st_nxt.port[p].data[15:0] = lo_in[p].pkt[15:0];
						st_nxt.port[p].data[66:64] = lo_in[p].pkt[18:16];
						st_nxt.port[p].addr[11:0] = lo_in[p].addr;
						st_nxt.port[p].subs[1:0] = lo_in[p].subs; // RULE_13
						st_nxt.port[p].bank[0] = lo_in[p].bank[0];
						st_nxt.port[p].bank[2] = lo_in[p].bank[1];
						st_nxt.port[p].rtype[1:0] = lo_in[p].rtype;
					end else begin // RULE_07
						st_nxt.port[p].data[31:16] = lo_in[p].pkt[15:0];
						st_nxt.port[p].data[69:67] = lo_in[p].pkt[18:16];
					end
				end
				if (hi_in[p].valid && !st_r.port[p].hi_got) begin // RULE_18
					st_nxt.port[p].hi_got = 1'b1;
					if (!st_r.port[p].phase) begin // RULE_17
						st_nxt.port[p].data[47:32] = hi_in[p].pkt[15:0];
						st_nxt.port[p].data[72:70] = hi_in[p].pkt[18:16];
						st_nxt.port[p].addr[23:12] = hi_in[p].addr;
						st_nxt.port[p].subs[3:2] = hi_in[p].subs; // RULE_13
						st_nxt.port[p].bank[1] = hi_in[p].bank[0];
						st_nxt.port[p].bank[3] = hi_in[p].bank[1];
						st_nxt.port[p].rtype[3:2] = hi_in[p].rtype;
					end else begin // RULE_08
						st_nxt.port[p].data[63:48] = hi_in[p].pkt[15:0];
						st_nxt.port[p].data[75:73] = hi_in[p].pkt[18:16];
					end
				end
				if (st_nxt.port[p].lo_got && st_nxt.port[p].hi_got) begin
					st_nxt.port[p].lo_got = 1'b0;
					st_nxt.port[p].hi_got = 1'b0;
					if (!st_r.port[p].phase && st_nxt.port[p].wr) begin
						st_nxt.port[p].phase = 1'b1; // RULE_21
					end else begin
						st_nxt.port[p].phase = 1'b0; // RULE_11
						st_nxt.port[p].pend = 1'b1;
					end
				end
			end
		end

		// Group routers and bank controllers per section
		for (q = 0; q < `NSECT; q++) begin
			for (p = `PORTS_PER_SECT - 1; p >= 0; p--) begin // RULE_04
				if (st_r.port[q * `PORTS_PER_SECT + p].pend) begin
					grant_any[q] = 1'b1;
					grant_idx[q] = p[1:0];
				end
			end
			st_nxt.mem[q].cs = 1'b1; // RULE_06
			st_nxt.mem[q].we = 1'b0;
			st_nxt.mem[q].clk = 1'b0;
			st_nxt.stage[q].valid = 1'b0;
			word_in[q] = st_r.port[q * `PORTS_PER_SECT + 32'(grant_idx[q])].data;
			if (grant_any[q]) begin // RULE_05
				p = q * `PORTS_PER_SECT + 32'(grant_idx[q]);
				rt = st_r.port[p].rtype;
				st_nxt.port[p].pend = 1'b0;
				st_nxt.stage[q].valid = 1'b1;
				st_nxt.stage[q].rp = grant_idx[q]; // RULE_02 RULE_03
				st_nxt.stage[q].group = st_r.port[p].bank[1:0]; // RULE_01
				st_nxt.stage[q].bank_hi = st_r.port[p].bank[3:2]; // RULE_01
				st_nxt.stage[q].subs = st_r.port[p].subs; // RULE_13
				st_nxt.stage[q].rtype = rt;
				st_nxt.stage[q].dest = {st_r.port[p].data[38:32],
					st_r.port[p].data[6:0]}; // RULE_10
				st_nxt.mem[q].bank = {st_r.port[p].bank[1:0], st_r.port[p].bank[3:2]};
				st_nxt.mem[q].addr = st_r.port[p].addr;
				st_nxt.mem[q].wdata = word_out[q]; // RULE_16
				if (rt[`RT_IO_BIT] || rt == `RT_CPU_WR) begin // RULE_20
					st_nxt.mem[q].we = 1'b1; // RULE_06
					st_nxt.mem[q].clk = 1'b1;
				end else if (rt == `RT_READ) begin
					st_nxt.mem[q].clk = 1'b1;
				end else if (rt == `RT_SPARE_SET) begin
					st_nxt.spare_en = 1'b1; // RULE_16
					st_nxt.spare_pos = st_r.port[p].addr[`POS_W-1:0];
				end
			end
		end

		// Responses back to the originating port
		for (p = 0; p < `NPORT; p++) begin
			st_nxt.lo_out[p].valid = 1'b0;
			st_nxt.hi_out[p].valid = 1'b0;
		end
		for (q = 0; q < `NSECT; q++) begin
			if (st_r.stage[q].valid) begin
				resp_v[q] = 1'b1;
				p = q * `PORTS_PER_SECT + 32'(st_r.stage[q].rp); // RULE_03
				rt = st_r.stage[q].rtype;
				rd = '0;
				dst = st_r.stage[q].dest;
				if (rt[`RT_IO_BIT]) begin // RULE_22
					dst = {7'h00, 3'h0, rt[2:0], 1'b1};
				end else if (rt == `RT_CPU_WR) begin // RULE_22 RULE_09
					dst = {7'h00, `DEST_CPU_WR};
				end else if (rt == `RT_SPARE_SET) begin
					dst = {7'h00, `DEST_SPARE_SET};
				end else if (rt == `RT_READ) begin
					rd = unshift[q]; // RULE_16
				end else if (rt == `RT_SPARE_RD) begin
					rd[`POS_W-1:0] = st_r.spare_pos;
					rd[`POS_W] = st_r.spare_en;
				end
				rbank = {st_r.stage[q].bank_hi, st_r.stage[q].group}; // RULE_15
				st_nxt.lo_out[p].valid = 1'b1; // RULE_09
				st_nxt.lo_out[p].data = {rd[69:64], rd[31:0]};
				st_nxt.lo_out[p].dest = dst[6:0]; // RULE_19
				st_nxt.lo_out[p].bank = {1'b0, rbank[2:0]}; // RULE_19 RULE_12
				st_nxt.lo_out[p].subs = st_r.stage[q].subs[1:0]; // RULE_13
				st_nxt.hi_out[p].valid = 1'b1;
				st_nxt.hi_out[p].data = {rd[75:70], rd[63:32]};
				st_nxt.hi_out[p].dest = dst[13:7]; // RULE_19
				st_nxt.hi_out[p].bank = {3'h0, rbank[3]}; // RULE_14
				st_nxt.hi_out[p].subs = st_r.stage[q].subs[3:2]; // RULE_13
			end
		end
		st_nxt.count = st_r.count + `CNT_W'(resp_v[0]) + `CNT_W'(resp_v[1]);

		// APB register access
		if (psel && !penable) begin
			st_nxt.prdata = '0;
			st_nxt.pslverr = 1'b0;
			if (paddr == `APB_CTRL) begin
				st_nxt.prdata[`CTRL_EN_BIT] = st_r.spare_en;
				st_nxt.prdata[`CTRL_POS_MSB:`CTRL_POS_LSB] = st_r.spare_pos;
			end else if (paddr == `APB_STATUS) begin
				st_nxt.prdata[`CNT_W-1:0] = st_r.count;
			end else begin
				st_nxt.pslverr = 1'b1;
			end
		end
		if (psel && penable && pwrite && paddr == `APB_CTRL) begin
			st_nxt.spare_en = pwdata[`CTRL_EN_BIT]; // RULE_16
			st_nxt.spare_pos = pwdata[`CTRL_POS_MSB:`CTRL_POS_LSB];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	always_comb begin
		int p;
		p = 0;
		for (p = 0; p < `NPORT; p++) begin
			lo_resume[p] = !st_r.port[p].pend; // RULE_18
			hi_resume[p] = !st_r.port[p].pend;
		end
	end
	assign lo_out = st_r.lo_out;
	assign hi_out = st_r.hi_out;
	assign mem_out = st_r.mem;
	assign prdata = st_r.prdata;
	assign pready = 1'b1;
	assign pslverr = st_r.pslverr;

endmodule

// >>> rtl/steer_defines.svh
// Constants for the memory reference steering block
//
// How it works
// RULE_01: Bank bits 1:0 pick group, 3:2 pass on
// RULE_02: Router swaps bank bits 1:0 for return code
// RULE_03: Return code is originating port number within its section
// RULE_04: Router halves serve ports 0-3 and 4-7
// RULE_05: Bank controllers split by port section likewise
// RULE_06: Drive write enable, clock; chip select always on
// RULE_07: Sender splits write data over two packets
// RULE_08: Upper stage fans data to group routers
// RULE_09: Completed write returns valid response with codes
// RULE_10: Read destination code comes from first packet
// RULE_11: Read carries same fields, write flag zero
// RULE_12: Read response carries subsection, bank, destination
// RULE_13: Subsection bits pass through unmodified
// RULE_14: Returned bank bits 5-7 read zero
// RULE_15: Returned bank bits 1:0 rebuilt from group
// RULE_16: Spare bit shifts data around faulty chip
// RULE_17: Lower and upper receivers split fields
// RULE_18: Each half has own write, valid, resume; here only the lower write flag is used and both resumes follow one pend
// RULE_19: Lower returns dest 0-6, upper dest 7-13
// RULE_20: Four reference type bits select the function
// RULE_21: Write sends two packets, read sends one
// RULE_22: Write responses return forced destination codes
`ifndef STEER_DEFINES_SVH
`define STEER_DEFINES_SVH

`define NPORT 8
`define NSECT 2
`define PORTS_PER_SECT 4
`define WORD_W 76
`define STACK_W 77
`define PKT_W 19
`define HALF_DATA_W 38
`define ADDR_W 24
`define HALF_ADDR_W 12
`define DEST_W 14
`define HALF_DEST_W 7
`define POS_W 7

`define RT_ABORT 4'h0
`define RT_READ 4'h1
`define RT_CPU_WR 4'h2
`define RT_SPARE_SET 4'h4
`define RT_SPARE_RD 4'h6
`define RT_IO_BIT 3

`define DEST_CPU_WR 7'h02
`define DEST_SPARE_SET 7'h06

`define APB_CTRL 12'h000
`define APB_STATUS 12'h004
`define CTRL_EN_BIT 0
`define CTRL_POS_LSB 8
`define CTRL_POS_MSB 14
`define CNT_W 16

`endif

// >>> rtl/steer_pkg.sv
// Types for the memory reference steering block
`include "steer_defines.svh"
package steer_pkg;

	// One half of a processor's port pair, inbound
	typedef struct packed {
		logic valid;
		logic write_ref;
		logic [`PKT_W-1:0] pkt;
		logic [`HALF_ADDR_W-1:0] addr;
		logic [1:0] subs;
		logic [1:0] bank;
		logic [1:0] rtype;
	} half_in_type;

	// One half of a response, outbound
	typedef struct packed {
		logic valid;
		logic [`HALF_DATA_W-1:0] data;
		logic [`HALF_DEST_W-1:0] dest;
		logic [3:0] bank;
		logic [1:0] subs;
	} half_out_type;

	// Assembled reference held in a port receiver
	typedef struct packed {
		logic lo_got;
		logic hi_got;
		logic phase;
		logic pend;
		logic wr;
		logic [`WORD_W-1:0] data;
		logic [`ADDR_W-1:0] addr;
		logic [3:0] subs;
		logic [3:0] bank;
		logic [3:0] rtype;
	} ref_type;

	// Bank controller to memory stack
	typedef struct packed {
		logic cs;
		logic we;
		logic clk;
		logic [3:0] bank;
		logic [`ADDR_W-1:0] addr;
		logic [`STACK_W-1:0] wdata;
	} mem_out_type;

	// Reference waiting one cycle for stack read data
	typedef struct packed {
		logic valid;
		logic [1:0] rp;
		logic [1:0] group;
		logic [1:0] bank_hi;
		logic [3:0] subs;
		logic [3:0] rtype;
		logic [`DEST_W-1:0] dest;
	} stage_type;

	// Whole state of the block
	typedef struct packed {
		ref_type [`NPORT-1:0] port;
		stage_type [`NSECT-1:0] stage;
		half_out_type [`NPORT-1:0] lo_out;
		half_out_type [`NPORT-1:0] hi_out;
		mem_out_type [`NSECT-1:0] mem;
		logic spare_en;
		logic [`POS_W-1:0] spare_pos;
		logic [`CNT_W-1:0] count;
		logic [31:0] prdata;
		logic pslverr;
	} state_type;

endpackage

// >>> testbench/mem_stack_model.sv
// Behavioural memory stack for one section
`timescale 1ns/1ps
`include "steer_defines.svh"
module mem_stack_model (
	// Clock
	input wire logic pclk,
	// Stack controls and data
	input wire steer_pkg::mem_out_type mem,
	output logic [`STACK_W-1:0] rdata
);
	logic [`STACK_W-1:0] store [0:255];
	logic [7:0] key;
	initial begin
		for (int k = 0; k < 256; k++) begin
			store[k] = '0;
		end
	end
	assign key = {mem.bank, mem.addr[7:4]};
	always @(posedge pclk) begin
		if (mem.clk && mem.cs && mem.we) begin
			store[key] <= mem.wdata;
		end
	end
	// Read word stands in the cycle of a read pulse (clock with write enable low), inverse otherwise
	assign rdata = (mem.clk && mem.cs && !mem.we) ? store[key] : ~store[key];
endmodule

// >>> testbench/steer_sva.sv
// Checker for the memory reference steering block
`timescale 1ns/1ps
`include "steer_defines.svh"
module steer_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Processor ports
	input wire logic [`NPORT-1:0] lo_resume,
	input wire logic [`NPORT-1:0] hi_resume,
	input wire steer_pkg::half_in_type [`NPORT-1:0] lo_in,
	input wire steer_pkg::half_in_type [`NPORT-1:0] hi_in,
	input wire steer_pkg::half_out_type [`NPORT-1:0] lo_out,
	input wire steer_pkg::half_out_type [`NPORT-1:0] hi_out,
	// Memory stack
	input wire steer_pkg::mem_out_type [`NSECT-1:0] mem_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic lo_any;
	assign lo_any = lo_out[0].valid | lo_out[1].valid | lo_out[2].valid | lo_out[3].valid;
	sequence s_rd;
		lo_in[0].valid && hi_in[0].valid && lo_resume[0] && hi_resume[0] && !lo_in[0].write_ref;
	endsequence
	property p_cs; $past(presetn) |-> mem_out[0].cs && mem_out[1].cs; endproperty
	a_cs: assert property (p_cs) else $error("chip select low");
	property p_pair; lo_out[0].valid |-> hi_out[0].valid; endproperty
	a_pair: assert property (p_pair) else $error("halves not paired");
	property p_hibank; hi_out[0].valid |-> hi_out[0].bank[3:1] == 3'h0; endproperty
	a_hibank: assert property (p_hibank) else $error("upper bank bits set");
	property p_lobank; lo_out[5].valid |-> !lo_out[5].bank[3]; endproperty
	a_lobank: assert property (p_lobank) else $error("lower bank bit 3 set");
	property p_ret; mem_out[0].clk |-> ##1 lo_any; endproperty
	a_ret: assert property (p_ret) else $error("no response after access");
	property p_sect; lo_out[5].valid |-> $past(mem_out[1].clk, 1); endproperty
	a_sect: assert property (p_sect) else $error("wrong section used");
	property p_busy; s_rd |=> !lo_resume[0]; endproperty
	a_busy: assert property (p_busy) else $error("resume stayed high");
	property p_lat; s_rd |-> ##3 lo_out[0].valid; endproperty
	a_lat: assert property (p_lat) else $error("read response late");
endmodule

bind memory_reference_steering steer_sva u_sva (.pclk(pclk), .presetn(presetn),
	.lo_resume(lo_resume), .hi_resume(hi_resume), .lo_in(lo_in), .hi_in(hi_in),
	.lo_out(lo_out), .hi_out(hi_out), .mem_out(mem_out));

// >>> testbench/testbench.sv
// Self-checking bench for the memory reference steering block
`timescale 1ns/1ps
`include "steer_defines.svh"
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	steer_pkg::half_in_type [`NPORT-1:0] lo_in = '0;
	steer_pkg::half_in_type [`NPORT-1:0] hi_in = '0;
	logic [`NPORT-1:0] lo_resume;
	logic [`NPORT-1:0] hi_resume;
	steer_pkg::half_out_type [`NPORT-1:0] lo_out;
	steer_pkg::half_out_type [`NPORT-1:0] hi_out;
	steer_pkg::mem_out_type [`NSECT-1:0] mem_out;
	wire [`NSECT-1:0][`STACK_W-1:0] mem_rdata;
	int error_cnt = 0;
	int comparisons = 0;
	int resp_cnt = 0;
	always #4 pclk = ~pclk;
	memory_reference_steering u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lo_in(lo_in), .hi_in(hi_in),
		.lo_resume(lo_resume), .hi_resume(hi_resume), .lo_out(lo_out), .hi_out(hi_out),
		.mem_out(mem_out), .mem_rdata(mem_rdata));
	mem_stack_model u_mem0 (.pclk(pclk), .mem(mem_out[0]), .rdata(mem_rdata[0]));
	mem_stack_model u_mem1 (.pclk(pclk), .mem(mem_out[1]), .rdata(mem_rdata[1]));
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [75:0] dword(input logic [13:0] d);
		return {37'h0, d[13:7], 25'h0, d[6:0]};
	endfunction
	task automatic send(input int p, input logic wr, input logic [3:0] rt, input logic [23:0] a,
		input logic [3:0] bk, input logic [3:0] ss, input logic [75:0] x);
		for (int k = 0; k < (wr ? 2 : 1); k++) begin
			@(posedge pclk);
			lo_in[p] <= '{1'b1, wr, {x[64+3*k+:3], x[16*k+:16]}, a[11:0], ss[1:0],
				{bk[2], bk[0]}, rt[1:0]};
			hi_in[p] <= '{1'b1, wr, {x[70+3*k+:3], x[32+16*k+:16]}, a[23:12], ss[3:2],
				{bk[3], bk[1]}, rt[3:2]};
			do @(negedge pclk); while (!(lo_resume[p] && hi_resume[p]));
		end
		@(posedge pclk);
		lo_in[p].valid <= 1'b0;
		hi_in[p].valid <= 1'b0;
	endtask
	task automatic get(input int p, input logic [75:0] w, input logic [13:0] d,
		input logic [3:0] bk, input logic [3:0] ss, input logic dchk);
		int n;
		n = 0;
		while (lo_out[p].valid !== 1'b1 && n < 20) begin
			@(negedge pclk);
			n++;
		end
		resp_cnt++;
		chk({lo_out[p].valid, hi_out[p].valid}, 2'b11);
		chk({hi_out[p].dest, lo_out[p].dest}, d);
		chk({hi_out[p].bank, lo_out[p].bank}, {3'h0, bk[3], 1'b0, bk[2:0]});
		chk({hi_out[p].subs, lo_out[p].subs}, ss);
		if (dchk) chk({hi_out[p].data, lo_out[p].data},
			{w[75:70], w[63:32], w[69:64], w[31:0]});
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_wr_rd(input int p, input logic [3:0] bk, input logic [3:0] ss);
		logic [75:0] w;
		w = {bk, 72'h12_3456_789a_bcde_f012};
		send(p, 1'b1, 4'h2, 24'h00_0c30, bk, ss, w);
		get(p, w, 14'h0002, bk, ss, 1'b0);
		send(p, 1'b0, 4'h1, 24'h00_0c30, bk, ss, dword(14'h2a5c));
		get(p, w, 14'h2a5c, bk, ss, 1'b1);
		$display("write and read on port %0d done", p);
	endtask
	task automatic t_rtypes;
		logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'h6};
		foreach (codes[i]) begin
			send(1, 1'b0, codes[i], 24'h00_0010, 4'h3, 4'h5, dword({10'h155, codes[i]}));
			get(1, '0, {10'h155, codes[i]}, 4'h3, 4'h5, 1'b0);
		end
		send(1, 1'b1, 4'ha, 24'h00_0010, 4'h3, 4'h5, 76'h5a5);
		get(1, '0, 14'h0005, 4'h3, 4'h5, 1'b0);
		send(1, 1'b0, 4'h4, 24'h00_0005, 4'h3, 4'h5, '0);
		get(1, '0, 14'h0006, 4'h3, 4'h5, 1'b0);
		send(1, 1'b0, 4'h6, 24'h00_0010, 4'h3, 4'h5, dword(14'h0123));
		get(1, 76'h85, 14'h0123, 4'h3, 4'h5, 1'b1);
		$display("reference type codes done");
	endtask
	task automatic t_apb;
		logic [31:0] r;
		logic e;
		apb(1'b0, `APB_CTRL, 32'h0, r, e);
		chk({e, r}, {1'b0, 32'h0000_0501});
		apb(1'b1, `APB_CTRL, 32'h0000_2a01, r, e);
		apb(1'b0, `APB_CTRL, 32'h0, r, e);
		chk({e, r}, {1'b0, 32'h0000_2a01});
		apb(1'b1, `APB_CTRL, 32'h0, r, e);
		apb(1'b0, `APB_STATUS, 32'h0, r, e);
		chk({e, r}, {17'h0, resp_cnt[15:0]});
		apb(1'b0, 12'h020, 32'h0, r, e);
		chk(e, 1'b1);
		$display("register access done");
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		fork
			t_wr_rd(0, 4'h6, 4'ha);
			t_wr_rd(5, 4'hb, 4'h3);
		join
		t_rtypes;
		t_apb;
		test_done;
	end
	initial begin
		#20000;
		error_cnt++;
		test_done;
	end
endmodule
